// ==== rtl/cxmw_can_mode_wake.sv ====
// transceiver mode, wake detection and fault supervision
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - receive-only turns driver off, selectable only in chip Normal or Stop.
// - wake-capable selectable in Stop, Sleep, Restart, Normal; forced in Fail-Safe.
// - detected bus wake drives rx_data_out low until mode changes.
// - wake pattern is dominant, recessive, dominant phases within min/max wake times.
// - mode keeps reading wake-capable after a bus wake.
// - wake detection rearms on chip change to Stop, Sleep or Fail-Safe.
// - wake in Stop or Normal lowers irq, sets wake status, lowers rx data.
// - wake in Stop stays in Stop; controller commands Normal itself.
// - wake in Stop enables watchdog if disabled and wdog_on_bus_wake set.
// - wake in Sleep requests Restart then Normal, rx low, status readable.
// - wakes from Sleep, Restart, Fail-Safe give no interrupt and request Restart.
// - termination follows mode: half, half or 2.5V, ground then 2.5V, floating.
// - ground termination connects only after silence time in wake-capable mode.
// - tx dominant beyond timeout in normal mode disables transmitter.
// - tx timeout leaves mode bits unchanged and sets transceiver fail flag.
// - transmitter resumes in normal mode once tx dominant condition ends.
// - bus dominant beyond clamp time in normal/rx-only sets fail flag.
// - clamp time must exceed tx timeout.
// - supply undervoltage in normal/rx-only sets flag and disables transmitter.
// - transmitter returns to normal once supply recovers.
// - undervoltage monitored only while upper mode bit is one.
// - off mode after reset, allowed in every chip mode except Fail-Safe, wakes ignored.
module cxmw_can_mode_wake #(
   parameter int WAKE_MIN_CYC = cxmw_pkg::CXMW_WAKE_MIN_CYC,
   parameter int WAKE_MAX_CYC = cxmw_pkg::CXMW_WAKE_MAX_CYC,
   parameter int SILENCE_CYC = cxmw_pkg::CXMW_SILENCE_CYC,
   parameter int TX_TO_CYC = cxmw_pkg::CXMW_TX_TO_CYC,
   parameter int CLAMP_CYC = cxmw_pkg::CXMW_CLAMP_CYC
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire cxmw_pkg::cxmw_chip_t chipMode,
   input wire cxmw_pkg::cxmw_xmode_t modeReq,
   input wire logic modeReqStb,
   input wire logic wdogEnabled,
   input wire logic wdog_on_bus_wake,
   input wire logic statusClr,
   input wire logic tx_data_in,
   input wire logic busRxPin,
   input wire logic supplyUvPin,
   output logic rx_data_out,
   output logic irq_out_n,
   output logic busDriveDom,
   output logic txEnable,
   output cxmw_pkg::cxmw_xmode_t xcvrMode,
   output cxmw_pkg::cxmw_term_t termSel,
   output cxmw_pkg::cxmw_status_t wake_status_reg,
   output logic xcvr_supply_undervolt_flag,
   output logic wdogEnableReq,
   output logic restartReq
);
   localparam int CW = cxmw_pkg::CXMW_CNT_W;

   // ****************************************
   // elaboration checks
   // ****************************************
   initial begin
      if (CLAMP_CYC <= TX_TO_CYC) begin
         $error("clamp time must exceed tx timeout");
      end
      if (WAKE_MIN_CYC < 1 || WAKE_MAX_CYC <= WAKE_MIN_CYC || SILENCE_CYC < 1 ||
          CLAMP_CYC >= (1 << CW) || SILENCE_CYC >= (1 << CW)) begin
         $error("timing parameters out of range");
      end
   end

   // ****************************************
   // input synchronisers
   // ****************************************
   logic [2:0] busSync_r;
   logic [2:0] uvSync_r;
   logic busDom_r;
   logic uvLvl_r;

   // bus resets recessive so no false wake edge follows reset
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         busSync_r <= 3'h7;
         uvSync_r <= 3'h0;
         busDom_r <= 1'b0;
         uvLvl_r <= 1'b0;
      end else begin
         busSync_r <= {busSync_r[1:0], busRxPin};
         uvSync_r <= {uvSync_r[1:0], supplyUvPin};
         if (busSync_r[1] == busSync_r[2]) begin
            busDom_r <= ~busSync_r[2];
         end
         if (uvSync_r[1] == uvSync_r[2]) begin
            uvLvl_r <= uvSync_r[2];
         end
      end
   end

   // ****************************************
   // mode control
   // ****************************************
   cxmw_pkg::cxmw_chip_t chipPrev_r;
   logic wakeHit;
   logic woken_r;
   logic modeChg;
   logic reqOk;
   logic rearmChip;

   always_comb begin
      unique case (modeReq)
         cxmw_pkg::CXMW_OFF: reqOk = 1'b1;
         cxmw_pkg::CXMW_RXONLY: reqOk = chipMode == cxmw_pkg::CXMW_CHIP_NORMAL ||
                                        chipMode == cxmw_pkg::CXMW_CHIP_STOP;
         cxmw_pkg::CXMW_WAKE: reqOk = chipMode != cxmw_pkg::CXMW_CHIP_FAILSAFE;
         cxmw_pkg::CXMW_NORMAL: reqOk = chipMode == cxmw_pkg::CXMW_CHIP_NORMAL;
      endcase
   end

   assign rearmChip = chipMode != chipPrev_r &&
                      (chipMode == cxmw_pkg::CXMW_CHIP_STOP || chipMode == cxmw_pkg::CXMW_CHIP_SLEEP ||
                       chipMode == cxmw_pkg::CXMW_CHIP_FAILSAFE);
   // fail-safe overrides the request, so a request neither changes the mode nor rearms
   assign modeChg = modeReqStb && reqOk && modeReq != xcvrMode &&
                    chipMode != cxmw_pkg::CXMW_CHIP_FAILSAFE;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         xcvrMode <= cxmw_pkg::CXMW_OFF;
         chipPrev_r <= cxmw_pkg::CXMW_CHIP_NORMAL;
      end else begin
         chipPrev_r <= chipMode;
         if (chipMode == cxmw_pkg::CXMW_CHIP_FAILSAFE) begin
            xcvrMode <= cxmw_pkg::CXMW_WAKE;
         end else if (modeReqStb && reqOk) begin
            xcvrMode <= modeReq;
         end
      end
   end

   // ****************************************
   // wake pattern detection
   // ****************************************
   cxmw_pkg::cxmw_wp_t wpState_r;
   logic [CW-1:0] wpCnt_r;
   logic wakeArmed;
   logic lvlChg;
   logic phaseOk;

   assign wakeArmed = xcvrMode == cxmw_pkg::CXMW_WAKE && !woken_r;
   assign lvlChg = busDom_r != (busSync_r[1] == 1'b0 && busSync_r[2] == 1'b0) &&
                   busSync_r[1] == busSync_r[2];
   assign phaseOk = wpCnt_r >= CW'(WAKE_MIN_CYC) && wpCnt_r < CW'(WAKE_MAX_CYC);
   assign wakeHit = wpState_r == cxmw_pkg::CXMW_WP_DOM2 && lvlChg && phaseOk;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wpState_r <= cxmw_pkg::CXMW_WP_IDLE;
         wpCnt_r <= '0;
      end else if (!wakeArmed) begin
         wpState_r <= cxmw_pkg::CXMW_WP_IDLE;
         wpCnt_r <= '0;
      end else begin
         // saturates so an over-long phase stays outside the window
         if (lvlChg) begin
            wpCnt_r <= '0;
         end else if (wpCnt_r != CW'(WAKE_MAX_CYC)) begin
            wpCnt_r <= wpCnt_r + 1'b1;
         end
         unique case (wpState_r)
            cxmw_pkg::CXMW_WP_IDLE: begin
               if (lvlChg && !busDom_r) begin
                  wpState_r <= cxmw_pkg::CXMW_WP_DOM1;
               end
            end
            cxmw_pkg::CXMW_WP_DOM1: begin
               if (lvlChg) begin
                  wpState_r <= phaseOk ? cxmw_pkg::CXMW_WP_REC : cxmw_pkg::CXMW_WP_IDLE;
               end
            end
            cxmw_pkg::CXMW_WP_REC: begin
               if (lvlChg) begin
                  wpState_r <= (phaseOk && wpCnt_r != CW'(WAKE_MIN_CYC)) ?
                               cxmw_pkg::CXMW_WP_DOM2 : cxmw_pkg::CXMW_WP_DOM1;
               end
            end
            cxmw_pkg::CXMW_WP_DOM2: begin
               if (lvlChg) begin
                  wpState_r <= phaseOk ? cxmw_pkg::CXMW_WP_DONE : cxmw_pkg::CXMW_WP_IDLE;
               end
            end
            cxmw_pkg::CXMW_WP_DONE: wpState_r <= cxmw_pkg::CXMW_WP_DONE;
            default: wpState_r <= cxmw_pkg::CXMW_WP_IDLE;
         endcase
      end
   end

   // ****************************************
   // wake signalling
   // ****************************************
   logic wakeIrqChip;

   assign wakeIrqChip = chipMode == cxmw_pkg::CXMW_CHIP_STOP || chipMode == cxmw_pkg::CXMW_CHIP_NORMAL;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         woken_r <= 1'b0;
         rx_data_out <= 1'b1;
         irq_out_n <= 1'b1;
         wdogEnableReq <= 1'b0;
         restartReq <= 1'b0;
      end else begin
         if (wakeHit) begin
            woken_r <= 1'b1;
         end else if (modeChg || rearmChip) begin
            woken_r <= 1'b0;
         end
         // wake latch wins over the live bus echo
         if (wakeHit) begin
            rx_data_out <= 1'b0;
         end else if (woken_r && !modeChg) begin
            rx_data_out <= 1'b0;
         end else begin
            rx_data_out <= !(xcvrMode[1] && busDom_r);
         end
         // irq level held until cleared, set wins
         if (wakeHit && wakeIrqChip) begin
            irq_out_n <= 1'b0;
         end else if (statusClr) begin
            irq_out_n <= 1'b1;
         end
         wdogEnableReq <= wakeHit && chipMode == cxmw_pkg::CXMW_CHIP_STOP &&
                          !wdogEnabled && wdog_on_bus_wake;
         restartReq <= wakeHit && !wakeIrqChip;
      end
   end

   // ****************************************
   // tx timeout and bus clamp
   // ****************************************
   logic [CW-1:0] txCnt_r;
   logic [CW-1:0] clampCnt_r;
   logic txTo_r;
   logic txDomIn;

   assign txDomIn = !tx_data_in;

   // count holds at the limit until tx goes recessive
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         txCnt_r <= '0;
         txTo_r <= 1'b0;
      end else if (xcvrMode != cxmw_pkg::CXMW_NORMAL || !txDomIn) begin
         txCnt_r <= '0;
         txTo_r <= 1'b0;
      end else if (txCnt_r == CW'(TX_TO_CYC)) begin
         txTo_r <= 1'b1;
      end else begin
         txCnt_r <= txCnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         clampCnt_r <= '0;
      end else if (!xcvrMode[1] || !busDom_r) begin
         clampCnt_r <= '0;
      end else if (clampCnt_r != CW'(CLAMP_CYC)) begin
         // saturating, fail flag sets again each cycle while clamped
         clampCnt_r <= clampCnt_r + 1'b1;
      end
   end

   // ****************************************
   // status flags, set wins over clear
   // ****************************************
   logic uvSet;
   logic failSet;

   assign uvSet = xcvrMode[1] && uvLvl_r;
   assign failSet = (txCnt_r == CW'(TX_TO_CYC) && txDomIn && xcvrMode == cxmw_pkg::CXMW_NORMAL) ||
                    clampCnt_r == CW'(CLAMP_CYC);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wake_status_reg <= '0;
         xcvr_supply_undervolt_flag <= 1'b0;
      end else begin
         wake_status_reg.busWake <= wakeHit || (wake_status_reg.busWake && !statusClr);
         wake_status_reg.xcvrFail <= failSet || (wake_status_reg.xcvrFail && !statusClr);
         wake_status_reg.txTimeout <= (failSet && !busDom_r) || txTo_r ||
                                      (wake_status_reg.txTimeout && !statusClr);
         wake_status_reg.supplyUv <= uvSet || (wake_status_reg.supplyUv && !statusClr);
         xcvr_supply_undervolt_flag <= uvSet || (xcvr_supply_undervolt_flag && !statusClr);
      end
   end

   // ****************************************
   // driver and termination
   // ****************************************
   logic [CW-1:0] silCnt_r;
   logic silDone;

   assign silDone = silCnt_r == CW'(SILENCE_CYC);

   // silence count restarts on every entry to wake-capable mode
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         silCnt_r <= '0;
      end else if (xcvrMode != cxmw_pkg::CXMW_WAKE) begin
         silCnt_r <= '0;
      end else if (!silDone) begin
         silCnt_r <= silCnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         txEnable <= 1'b0;
         busDriveDom <= 1'b0;
      end else begin
         // transmitter resumes as soon as timeout or undervoltage clears
         txEnable <= xcvrMode == cxmw_pkg::CXMW_NORMAL && !txTo_r && !uvLvl_r;
         busDriveDom <= xcvrMode == cxmw_pkg::CXMW_NORMAL && !txTo_r && !uvLvl_r && txDomIn;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         termSel <= cxmw_pkg::CXMW_TERM_FLOAT;
      end else begin
         unique case (xcvrMode)
            cxmw_pkg::CXMW_NORMAL: termSel <= cxmw_pkg::CXMW_TERM_HALF;
            cxmw_pkg::CXMW_RXONLY: termSel <= uvLvl_r ? cxmw_pkg::CXMW_TERM_2V5 : cxmw_pkg::CXMW_TERM_HALF;
            cxmw_pkg::CXMW_WAKE: termSel <= woken_r ? cxmw_pkg::CXMW_TERM_2V5 :
                                            (silDone ? cxmw_pkg::CXMW_TERM_GND : cxmw_pkg::CXMW_TERM_FLOAT);
            cxmw_pkg::CXMW_OFF: termSel <= cxmw_pkg::CXMW_TERM_FLOAT;
         endcase
      end
   end
endmodule

`default_nettype wire

// ==== rtl/cxmw_pkg.sv ====
// package for the transceiver mode and wake control block
package cxmw_pkg;
   // transceiver mode encoding, upper bit enables undervoltage monitoring
   typedef enum logic [1:0] {
      CXMW_OFF = 2'h0,
      CXMW_WAKE = 2'h1,
      CXMW_RXONLY = 2'h2,
      CXMW_NORMAL = 2'h3
   } cxmw_xmode_t;
   typedef enum logic [2:0] {
      CXMW_CHIP_NORMAL = 3'h0,
      CXMW_CHIP_STOP = 3'h1,
      CXMW_CHIP_SLEEP = 3'h2,
      CXMW_CHIP_RESTART = 3'h3,
      CXMW_CHIP_FAILSAFE = 3'h4
   } cxmw_chip_t;
   typedef enum logic [1:0] {
      CXMW_TERM_FLOAT = 2'h0,
      CXMW_TERM_HALF = 2'h1,
      CXMW_TERM_GND = 2'h2,
      CXMW_TERM_2V5 = 2'h3
   } cxmw_term_t;
   // wake pattern detector states, gray along the path
   typedef enum logic [2:0] {
      CXMW_WP_IDLE = 3'h0,
      CXMW_WP_DOM1 = 3'h1,
      CXMW_WP_REC = 3'h3,
      CXMW_WP_DOM2 = 3'h2,
      CXMW_WP_DONE = 3'h6
   } cxmw_wp_t;
   typedef struct packed {
      logic xcvrFail;
      logic supplyUv;
      logic busWake;
      logic txTimeout;
   } cxmw_status_t;
   localparam int CXMW_CLK_MHZ = 100;
   localparam int CXMW_WAKE_MIN_US = 1;
   localparam int CXMW_WAKE_MAX_US = 5;
   localparam int CXMW_SILENCE_US = 1000;
   localparam int CXMW_TX_TO_US = 2000;
   localparam int CXMW_CLAMP_US = 4000;
   localparam int CXMW_WAKE_MIN_CYC = CXMW_WAKE_MIN_US * CXMW_CLK_MHZ;
   localparam int CXMW_WAKE_MAX_CYC = CXMW_WAKE_MAX_US * CXMW_CLK_MHZ;
   localparam int CXMW_SILENCE_CYC = CXMW_SILENCE_US * CXMW_CLK_MHZ;
   localparam int CXMW_TX_TO_CYC = CXMW_TX_TO_US * CXMW_CLK_MHZ;
   localparam int CXMW_CLAMP_CYC = CXMW_CLAMP_US * CXMW_CLK_MHZ;
   localparam int CXMW_CNT_W = 24;
endpackage

// ==== tb/cxmw_bus_model.sv ====
// far-side model: bus wiring with an external dominant source
`timescale 1ns/1ps
`default_nettype none
module cxmw_bus_model (
   input wire logic clk,
   input wire logic busDriveDom,
   output logic busRxPin
);
   logic extDom = 1'b0;
   // wired bus, recessive high through termination
   assign busRxPin = ~(busDriveDom | extDom);
   task automatic hold(input logic dom, input int n);
      extDom = dom;
      repeat (n) @(negedge clk);
   endtask
   task automatic sendWake(input int d, input int r);
      hold(1'b1, d);
      hold(1'b0, r);
      hold(1'b1, d);
      hold(1'b0, 2);
   endtask
endmodule
`default_nettype wire

// ==== tb/cxmw_props.sv ====
// concurrent checks for the transceiver mode and wake control block
`timescale 1ns/1ps
`default_nettype none
module cxmw_props #(
   parameter int SILENCE_CYC = 10,
   parameter int TX_TO_CYC = 50
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire cxmw_pkg::cxmw_chip_t chipMode,
   input wire cxmw_pkg::cxmw_xmode_t modeReq,
   input wire logic modeReqStb,
   input wire logic tx_data_in,
   input wire logic supplyUvPin,
   input wire logic rx_data_out,
   input wire logic irq_out_n,
   input wire logic busDriveDom,
   input wire logic txEnable,
   input wire cxmw_pkg::cxmw_xmode_t xcvrMode,
   input wire cxmw_pkg::cxmw_term_t termSel,
   input wire cxmw_pkg::cxmw_status_t wake_status_reg,
   input wire logic xcvr_supply_undervolt_flag,
   input wire logic restartReq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   int txLow_r;
   int wakeCyc_r;
   // cycles of dominant transmit data in normal mode
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         txLow_r <= 0;
      end else begin
         txLow_r <= (xcvrMode == cxmw_pkg::CXMW_NORMAL && !tx_data_in) ? txLow_r + 1 : 0;
      end
   end
   // cycles spent in wake-capable mode
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wakeCyc_r <= 0;
      end else begin
         wakeCyc_r <= (xcvrMode == cxmw_pkg::CXMW_WAKE) ? wakeCyc_r + 1 : 0;
      end
   end
   a_rxonly_refused: assert property (modeReqStb && modeReq == cxmw_pkg::CXMW_RXONLY &&
      chipMode inside {cxmw_pkg::CXMW_CHIP_SLEEP, cxmw_pkg::CXMW_CHIP_RESTART} |=> $stable(xcvrMode))
      else $error("rx-only taken in wrong chip mode");
   a_driver_off: assert property (xcvrMode != cxmw_pkg::CXMW_NORMAL &&
      $past(xcvrMode) != cxmw_pkg::CXMW_NORMAL |-> !txEnable && !busDriveDom)
      else $error("driver active outside normal mode");
   a_wake_rx_hold: assert property (xcvrMode == cxmw_pkg::CXMW_WAKE && !rx_data_out &&
      !modeReqStb && $stable(chipMode) |=> !rx_data_out)
      else $error("rx released while wake held");
   a_wake_irq: assert property ($rose(wake_status_reg.busWake) && $stable(chipMode) &&
      chipMode inside {cxmw_pkg::CXMW_CHIP_NORMAL, cxmw_pkg::CXMW_CHIP_STOP} |-> !irq_out_n && !rx_data_out)
      else $error("wake not signalled");
   a_sleep_noirq: assert property ($rose(wake_status_reg.busWake) && $stable(chipMode) &&
      chipMode inside {cxmw_pkg::CXMW_CHIP_SLEEP, cxmw_pkg::CXMW_CHIP_RESTART, cxmw_pkg::CXMW_CHIP_FAILSAFE}
      |-> $stable(irq_out_n) && restartReq)
      else $error("wake from low power mishandled");
   a_txto_fail: assert property (txLow_r > TX_TO_CYC + 2 |->
      !txEnable && !busDriveDom && wake_status_reg.xcvrFail)
      else $error("transmit timeout not taken");
   a_uv_flag: assert property ((xcvrMode[1] && supplyUvPin) [*8] |->
      xcvr_supply_undervolt_flag && !txEnable)
      else $error("undervoltage not handled");
   a_gnd_silence: assert property (termSel == cxmw_pkg::CXMW_TERM_GND |->
      $past(xcvrMode) == cxmw_pkg::CXMW_WAKE && $past(wakeCyc_r) >= SILENCE_CYC - 2)
      else $error("ground termination too early");
endmodule
bind cxmw_can_mode_wake cxmw_props #(.SILENCE_CYC(SILENCE_CYC), .TX_TO_CYC(TX_TO_CYC)) uProps (
   .clk(clk), .arst_n(arst_n), .chipMode(chipMode), .modeReq(modeReq), .modeReqStb(modeReqStb),
   .tx_data_in(tx_data_in), .supplyUvPin(supplyUvPin), .rx_data_out(rx_data_out), .irq_out_n(irq_out_n),
   .busDriveDom(busDriveDom), .txEnable(txEnable), .xcvrMode(xcvrMode), .termSel(termSel),
   .wake_status_reg(wake_status_reg), .xcvr_supply_undervolt_flag(xcvr_supply_undervolt_flag),
   .restartReq(restartReq));
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the transceiver mode and wake control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
`define WAIT(c) begin for (int k = 0; k < 300 && !(c); k++) @(negedge clk); \
   if (!(c)) begin failures++; print_verdict(); end end
module tb_top;
   localparam int SIL = 10;
   localparam int TXTO = 50;
   localparam int CLAMP = 100;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   cxmw_pkg::cxmw_chip_t chipMode = cxmw_pkg::CXMW_CHIP_NORMAL;
   cxmw_pkg::cxmw_xmode_t modeReq = cxmw_pkg::CXMW_OFF;
   cxmw_pkg::cxmw_xmode_t expM;
   cxmw_pkg::cxmw_xmode_t xMode;
   cxmw_pkg::cxmw_term_t term;
   cxmw_pkg::cxmw_status_t stat;
   logic modeReqStb = 1'b0;
   logic statusClr = 1'b0;
   logic txData = 1'b1;
   logic uvPin = 1'b0;
   logic wdSeen = 1'b0;
   logic rsSeen = 1'b0;
   logic busRx, rxOut, irqN, drvDom, txEn, uvFlag, wdReq, rsReq;
   logic [31:0] seed = 32'h6520d9ff;
   int failures = 0;
   int num_checks = 0;
   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (wdReq === 1'b1) wdSeen <= 1'b1;
      if (rsReq === 1'b1) rsSeen <= 1'b1;
   end
   cxmw_can_mode_wake #(.WAKE_MIN_CYC(4), .WAKE_MAX_CYC(20), .SILENCE_CYC(SIL), .TX_TO_CYC(TXTO),
      .CLAMP_CYC(CLAMP)) DUT (.clk(clk), .arst_n(arst_n), .chipMode(chipMode), .modeReq(modeReq),
      .modeReqStb(modeReqStb), .wdogEnabled(1'b0), .wdog_on_bus_wake(1'b1), .statusClr(statusClr),
      .tx_data_in(txData), .busRxPin(busRx), .supplyUvPin(uvPin), .rx_data_out(rxOut), .irq_out_n(irqN),
      .busDriveDom(drvDom), .txEnable(txEn), .xcvrMode(xMode), .termSel(term), .wake_status_reg(stat),
      .xcvr_supply_undervolt_flag(uvFlag), .wdogEnableReq(wdReq), .restartReq(rsReq));
   cxmw_bus_model bus (.clk(clk), .busDriveDom(drvDom), .busRxPin(busRx));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   function automatic cxmw_pkg::cxmw_xmode_t nextMode(input cxmw_pkg::cxmw_xmode_t cur,
      input cxmw_pkg::cxmw_chip_t c, input cxmw_pkg::cxmw_xmode_t r);
      case (r)
         cxmw_pkg::CXMW_RXONLY: return (c inside {cxmw_pkg::CXMW_CHIP_NORMAL, cxmw_pkg::CXMW_CHIP_STOP}) ? r : cur;
         cxmw_pkg::CXMW_WAKE: return (c != cxmw_pkg::CXMW_CHIP_FAILSAFE) ? r : cur;
         cxmw_pkg::CXMW_NORMAL: return (c == cxmw_pkg::CXMW_CHIP_NORMAL) ? r : cur;
         default: return r;
      endcase
   endfunction
   task automatic req(input cxmw_pkg::cxmw_xmode_t m);
      modeReq = m;
      modeReqStb = 1'b1;
      @(negedge clk);
      modeReqStb = 1'b0;
      @(negedge clk);
   endtask
   task automatic chip(input cxmw_pkg::cxmw_chip_t c);
      chipMode = c;
      repeat (2) @(negedge clk);
   endtask
   task automatic pulseClr();
      statusClr = 1'b1;
      @(negedge clk);
      statusClr = 1'b0;
      @(negedge clk);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(negedge clk);
      arst_n = 1'b1;
      @(negedge clk);
      `CHK(xMode, cxmw_pkg::CXMW_OFF)
      `CHK(term, cxmw_pkg::CXMW_TERM_FLOAT)
      uvPin = 1'b1;
      repeat (10) @(negedge clk);
      `CHK(uvFlag, 1'b0)
      uvPin = 1'b0;
      expM = cxmw_pkg::CXMW_OFF;
      for (int i = 0; i < 40; i++) begin
         seed = xs(seed);
         chip(cxmw_pkg::cxmw_chip_t'(seed[1:0]));
         expM = nextMode(expM, chipMode, cxmw_pkg::cxmw_xmode_t'(seed[5:4]));
         req(cxmw_pkg::cxmw_xmode_t'(seed[5:4]));
         `CHK(xMode, expM)
      end
      chip(cxmw_pkg::CXMW_CHIP_RESTART);
      req(cxmw_pkg::CXMW_OFF);
      req(cxmw_pkg::CXMW_RXONLY);
      `CHK(xMode, cxmw_pkg::CXMW_OFF)
      chip(cxmw_pkg::CXMW_CHIP_FAILSAFE);
      `CHK(xMode, cxmw_pkg::CXMW_WAKE)
      $display("test modes done");
      chip(cxmw_pkg::CXMW_CHIP_NORMAL);
      req(cxmw_pkg::CXMW_OFF);
      bus.sendWake(8, 8);
      `CHK(stat.busWake, 1'b0)
      chip(cxmw_pkg::CXMW_CHIP_STOP);
      req(cxmw_pkg::CXMW_WAKE);
      `WAIT(term === cxmw_pkg::CXMW_TERM_GND)
      bus.sendWake(8, 8);
      `WAIT(rxOut === 1'b0)
      @(negedge clk);
      `CHK(irqN, 1'b0)
      `CHK(stat.busWake, 1'b1)
      `CHK(xMode, cxmw_pkg::CXMW_WAKE)
      `CHK(rsSeen, 1'b0)
      `CHK(wdSeen, 1'b1)
      repeat (30) @(negedge clk);
      `CHK(rxOut, 1'b0)
      `CHK(term, cxmw_pkg::CXMW_TERM_2V5)
      pulseClr();
      `CHK(irqN, 1'b1)
      req(cxmw_pkg::CXMW_OFF);
      `CHK(rxOut, 1'b1)
      $display("test stop wake done");
      req(cxmw_pkg::CXMW_WAKE);
      chip(cxmw_pkg::CXMW_CHIP_SLEEP);
      `WAIT(term === cxmw_pkg::CXMW_TERM_GND)
      bus.sendWake(8, 8);
      `WAIT(rxOut === 1'b0)
      @(negedge clk);
      `CHK(irqN, 1'b1)
      `CHK(rsSeen, 1'b1)
      `CHK(stat.busWake, 1'b1)
      pulseClr();
      $display("test sleep wake done");
      chip(cxmw_pkg::CXMW_CHIP_NORMAL);
      req(cxmw_pkg::CXMW_NORMAL);
      repeat (5) @(negedge clk);
      `CHK(term, cxmw_pkg::CXMW_TERM_HALF)
      txData = 1'b0;
      repeat (4) @(negedge clk);
      `CHK(drvDom, 1'b1)
      repeat (TXTO + 4) @(negedge clk);
      `CHK(txEn, 1'b0)
      `CHK(drvDom, 1'b0)
      `CHK(stat.xcvrFail, 1'b1)
      `CHK(xMode, cxmw_pkg::CXMW_NORMAL)
      txData = 1'b1;
      repeat (4) @(negedge clk);
      `CHK(txEn, 1'b1)
      pulseClr();
      $display("test tx timeout done");
      req(cxmw_pkg::CXMW_RXONLY);
      `CHK(stat.xcvrFail, 1'b0)
      bus.hold(1'b1, CLAMP + 10);
      `CHK(stat.xcvrFail, 1'b1)
      `CHK(xMode, cxmw_pkg::CXMW_RXONLY)
      `CHK(rxOut, 1'b0)
      bus.hold(1'b0, 4);
      pulseClr();
      $display("test clamp done");
      req(cxmw_pkg::CXMW_NORMAL);
      uvPin = 1'b1;
      repeat (10) @(negedge clk);
      `CHK(uvFlag, 1'b1)
      `CHK(txEn, 1'b0)
      uvPin = 1'b0;
      repeat (10) @(negedge clk);
      `CHK(txEn, 1'b1)
      `CHK(xMode, cxmw_pkg::CXMW_NORMAL)
      $display("test undervoltage done");
      print_verdict();
   end
endmodule
`default_nettype wire
